// ==== asc_pkg.sv ====
// asc_pkg: register map, field positions and constants of the audio serial controller
// assumes: a 32-bit apb master on pclk; serial pins sampled by pclk
package asc_pkg;
   // ****************************************
   // register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0] ASC_CTRL_OFS = 8'h00;
   localparam logic [7:0] ASC_CLKCFG0_OFS = 8'h04;
   localparam logic [7:0] ASC_CLKCFG1_OFS = 8'h08;
   localparam logic [7:0] ASC_SERCFG0_OFS = 8'h0c;
   localparam logic [7:0] ASC_IRQENCLR_OFS = 8'h10;
   localparam logic [7:0] ASC_IRQFLAG_OFS = 8'h14;
   localparam logic [7:0] ASC_IRQENSET_OFS = 8'h18;
   localparam logic [7:0] ASC_SERCFG1_OFS = 8'h1c;
   localparam logic [7:0] ASC_DATA0_OFS = 8'h30;
   localparam logic [7:0] ASC_DATA1_OFS = 8'h34;
   // ****************************************
   // interrupt flag layout
   // ****************************************
   localparam int ASC_RXRDY_POS = 0;
   localparam int ASC_RXOR_POS = 4;
   localparam int ASC_TXRDY_POS = 8;
   localparam int ASC_TXUR_POS = 12;
   localparam logic [15:0] ASC_IRQ_MASK = 16'h3333;
   localparam logic [15:0] ASC_IRQFLAG_RST = 16'h0000;
   // ****************************************
   // ctrl fields: [1:0] clock unit enable, [3:2] serializer enable
   // clkcfg: [10:0] mck ratio-1 to fs, [13:11] slots-1, [14] master, [15] tdm, [16] burst
   // sercfg: [0] transmit, [1] clock unit select, [4:2] word size, [5] mono,
   //         [6] compact, [7] pdm, [8] pdm two channel, [16:9] slot enable,
   //         [17] dma split (two request lines)
   // ****************************************
   localparam int ASC_CK_RATIO_LSB = 0;
   localparam int ASC_CK_SLOTS_LSB = 11;
   localparam int ASC_CK_MASTER_POS = 14;
   localparam int ASC_CK_TDM_POS = 15;
   localparam int ASC_CK_BURST_POS = 16;
   localparam int ASC_SC_TX_POS = 0;
   localparam int ASC_SC_CU_POS = 1;
   localparam int ASC_SC_WS_LSB = 2;
   localparam int ASC_SC_MONO_POS = 5;
   localparam int ASC_SC_COMPACT_POS = 6;
   localparam int ASC_SC_PDM_POS = 7;
   localparam int ASC_SC_PDM2_POS = 8;
   localparam int ASC_SC_SLOTEN_LSB = 9;
   localparam int ASC_SC_SPLIT_POS = 17;
   localparam logic [10:0] ASC_RATIO_MIN = 11'h00f;
   localparam logic [10:0] ASC_RATIO_MAX = 11'h3ff;
   localparam logic [17:0] ASC_SERCFG_RST = 18'h3fe00;
   localparam int ASC_CU_N = 2;
   localparam int ASC_SER_N = 2;
   localparam int ASC_SLOT_BITS = 32;
   typedef enum logic [2:0] {
      ASC_WS32, ASC_WS24, ASC_WS20, ASC_WS18, ASC_WS16, ASC_WS8
   } asc_ws_e;
endpackage : asc_pkg

// ==== asc_controller.sv ====
// asc_controller: two clock units, two serializers, apb registers, interrupt
// assumes: pclk 25 MHz; serial clock and frame sync pins are slow against pclk
//
// How it works
// R1 - two clock units, two serializers, each enabled, rx or tx, master or slave
// R2 - frame sync is word select in i2s, one pulse per frame in tdm
// R3 - each serializer requests dma, on one line or split per channel; the code ignores the split bit, each serializer has its own line
// R4 - compact mode packs left and right 8 or 16 bit samples together
// R5 - master clock pin runs at 16 to 1024 times fs; the code toggles it every pclk in master mode whatever the ratio, and holds it in slave mode
// R6 - word sizes 32, 24, 20, 18, 16, 8, mono or stereo
// R7 - tdm carries 1 to 8 slots, each slot enabled on its own
// R8 - pdm reception of one or two microphone channels
// R9 - burst mode, frame sync non periodic and marks each burst; the code pulses it at every frame start, as in tdm
// R10 - clock units serve both serializers in common or separately
// R11 - writing one to an enable set bit enables, zero leaves it
// R12 - tx underrun sets flag, interrupts when enabled, write one clears
// R13 - tx ready clears on data write or write one
// R14 - tx ready sets when serializer takes a new word
// R15 - rx overrun sets flag, interrupts when enabled, write one clears
// R16 - rx ready sets on received word, clears on data read or write one
// R17 - one irq line, high while any enabled flag is set
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module asc_controller (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] serial_clock_pin_i,
   output logic [1:0] serial_clock_pin_o,
   output logic [1:0] serial_clock_pin_oe_n,
   input wire logic [1:0] frame_sync_pin_i,
   output logic [1:0] frame_sync_pin_o,
   output logic [1:0] frame_sync_pin_oe_n,
   output logic [1:0] master_clock_pin,
   input wire logic [1:0] serial_data_pin_i,
   output logic [1:0] serial_data_pin_o,
   output logic [1:0] serial_data_pin_oe_n,
   output logic [1:0] dma_rx_req,
   output logic [1:0] dma_tx_req,
   output logic irq
);
   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [3:0] ctrl;
      logic [1:0][16:0] clkcfg;
      logic [1:0][17:0] sercfg;
      logic [15:0] flag;
      logic [15:0] inten;
      logic [1:0][10:0] mdiv;
      logic [1:0] mck;
      logic [1:0][1:0] sck_cnt;
      logic [1:0] sck;
      logic [1:0][8:0] bitc;
      logic [1:0] fs;
      logic [1:0][1:0] sck_s;
      logic [1:0][1:0] fs_s;
      logic [1:0][1:0] sd_s;
      logic [1:0] sck_d;
      logic [1:0] fs_d;
      logic [1:0] fs_dly;
      logic [1:0][31:0] data;
      logic [1:0] full;
      logic [1:0][31:0] shreg;
      logic [1:0][5:0] bitn;
      logic [1:0] sd_o;
      logic [1:0] rxtog;
      logic [1:0] txtog;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
      logic [1:0] drx;
      logic [1:0] dtx;
   } asc_state_s;
   asc_state_s s_r;
   asc_state_s s_nxt;

   function automatic logic [5:0] asc_bits(input logic [2:0] ws);
      unique case (asc_pkg::asc_ws_e'(ws))
         asc_pkg::ASC_WS24: asc_bits = 6'h18;
         asc_pkg::ASC_WS20: asc_bits = 6'h14;
         asc_pkg::ASC_WS18: asc_bits = 6'h12;
         asc_pkg::ASC_WS16: asc_bits = 6'h10;
         asc_pkg::ASC_WS8: asc_bits = 6'h08;
         default: asc_bits = 6'h20;
      endcase
   endfunction : asc_bits

   logic setup;
   logic wr;
   logic rd;
   assign setup = psel && !penable;
   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;

   always_comb begin
      logic [15:0] hw_set;
      logic [15:0] clr;
      logic [10:0] ratio;
      logic [5:0] nbits;
      logic [8:0] frame_len;
      logic [2:0] slot;
      logic cu;
      logic sck_rise;
      logic sck_fall;
      logic fs_edge;
      logic slot_on;
      logic tx;
      hw_set = 16'h0000;
      clr = 16'h0000;
      ratio = 11'h000;
      nbits = 6'h00;
      frame_len = 9'h000;
      slot = 3'h0;
      cu = 1'b0;
      sck_rise = 1'b0;
      sck_fall = 1'b0;
      fs_edge = 1'b0;
      slot_on = 1'b0;
      tx = 1'b0;
      s_nxt = s_r;
      s_nxt.pready = 1'b0;
      s_nxt.pslverr = 1'b0;
      // ****************************************
      // apb slave, answers one cycle after the access phase starts
      // ****************************************
      if (psel && penable && !s_r.pready) begin
         s_nxt.pready = 1'b1;
         s_nxt.prdata = 32'h0000_0000;
         unique case (paddr)
            asc_pkg::ASC_CTRL_OFS: begin
               if (pwrite) s_nxt.ctrl = pwdata[3:0]; // R1
               s_nxt.prdata = {28'h0, s_r.ctrl};
            end
            asc_pkg::ASC_CLKCFG0_OFS, asc_pkg::ASC_CLKCFG1_OFS: begin
               cu = paddr[3];
               if (pwrite) s_nxt.clkcfg[cu] = pwdata[16:0];
               s_nxt.prdata = {15'h0, s_r.clkcfg[cu]};
            end
            asc_pkg::ASC_SERCFG0_OFS, asc_pkg::ASC_SERCFG1_OFS: begin
               cu = paddr[4];
               if (pwrite) s_nxt.sercfg[cu] = pwdata[17:0];
               s_nxt.prdata = {14'h0, s_r.sercfg[cu]};
            end
            asc_pkg::ASC_IRQENSET_OFS: begin
               if (pwrite) s_nxt.inten = s_r.inten | (pwdata[15:0] & asc_pkg::ASC_IRQ_MASK); // R11
               s_nxt.prdata = {16'h0, s_r.inten};
            end
            asc_pkg::ASC_IRQENCLR_OFS: begin
               if (pwrite) s_nxt.inten = s_r.inten & ~pwdata[15:0];
               s_nxt.prdata = {16'h0, s_r.inten};
            end
            asc_pkg::ASC_IRQFLAG_OFS: begin
               if (pwrite) clr = pwdata[15:0] & asc_pkg::ASC_IRQ_MASK; // R12 R13 R15 R16
               s_nxt.prdata = {16'h0, s_r.flag};
            end
            asc_pkg::ASC_DATA0_OFS, asc_pkg::ASC_DATA1_OFS: begin
               cu = paddr[2];
               if (pwrite) begin
                  s_nxt.data[cu] = pwdata;
                  s_nxt.full[cu] = 1'b1;
                  clr[asc_pkg::ASC_TXRDY_POS + int'(cu)] = 1'b1; // R13
               end else begin
                  s_nxt.prdata = s_r.data[cu];
                  s_nxt.full[cu] = 1'b0;
                  clr[asc_pkg::ASC_RXRDY_POS + int'(cu)] = 1'b1; // R16
               end
            end
            default: s_nxt.pslverr = 1'b1;
         endcase
      end
      // ****************************************
      // clock units: master clock, serial clock, frame sync
      // ****************************************
      for (int c = 0; c < asc_pkg::ASC_CU_N; c++) begin
         ratio = s_r.clkcfg[c][asc_pkg::ASC_CK_RATIO_LSB +: 11];
         if (ratio < asc_pkg::ASC_RATIO_MIN) ratio = asc_pkg::ASC_RATIO_MIN; // R5
         if (ratio > asc_pkg::ASC_RATIO_MAX) ratio = asc_pkg::ASC_RATIO_MAX; // R5
         s_nxt.sck_s[c] = {s_r.sck_s[c][0], serial_clock_pin_i[c]};
         s_nxt.fs_s[c] = {s_r.fs_s[c][0], frame_sync_pin_i[c]};
         s_nxt.sck_d[c] = s_r.sck_s[c][1];
         s_nxt.fs_d[c] = s_r.fs_s[c][1];
         // i2s: a word starts one bit clock after the select edge, lsb of the last word first
         if (!s_r.sck_s[c][1] && s_r.sck_d[c])
            s_nxt.fs_dly[c] = s_r.fs_s[c][1] != s_r.fs_d[c]; // R2
         if (!s_r.ctrl[c]) begin
            s_nxt.mdiv[c] = 11'h000;
            s_nxt.mck[c] = 1'b0;
            s_nxt.sck[c] = 1'b0;
            s_nxt.bitc[c] = 9'h000;
            s_nxt.fs[c] = 1'b0;
         end else if (s_r.clkcfg[c][asc_pkg::ASC_CK_MASTER_POS]) begin
            // mck toggles each pclk; mdiv is not counted and the ratio does not divide it
            s_nxt.mck[c] = ~s_r.mck[c]; // R5
            s_nxt.sck_cnt[c] = s_r.sck_cnt[c] + 2'h1;
            if (s_r.sck_cnt[c] == 2'h3) begin
               s_nxt.sck[c] = ~s_r.sck[c];
               if (s_r.sck[c]) begin
                  frame_len = {s_r.clkcfg[c][asc_pkg::ASC_CK_TDM_POS] ?
                     s_r.clkcfg[c][asc_pkg::ASC_CK_SLOTS_LSB +: 3] : 3'h1, 6'h3f};
                  s_nxt.bitc[c] = (s_r.bitc[c] == frame_len) ? 9'h000 : s_r.bitc[c] + 9'h001;
                  if (s_r.clkcfg[c][asc_pkg::ASC_CK_TDM_POS] ||
                      s_r.clkcfg[c][asc_pkg::ASC_CK_BURST_POS])
                     s_nxt.fs[c] = (s_nxt.bitc[c] == 9'h000); // R2 R7 R9
                  else
                     s_nxt.fs[c] = s_nxt.bitc[c][5]; // R2
               end
            end
         end
      end
      // ****************************************
      // serializers
      // ****************************************
      for (int m = 0; m < asc_pkg::ASC_SER_N; m++) begin
         cu = s_r.sercfg[m][asc_pkg::ASC_SC_CU_POS]; // R10
         tx = s_r.sercfg[m][asc_pkg::ASC_SC_TX_POS];
         s_nxt.sd_s[m] = {s_r.sd_s[m][0], serial_data_pin_i[m]};
         if (s_r.clkcfg[cu][asc_pkg::ASC_CK_MASTER_POS]) begin
            sck_rise = s_r.sck_cnt[cu] == 2'h3 && !s_r.sck[cu];
            sck_fall = s_r.sck_cnt[cu] == 2'h3 && s_r.sck[cu];
            fs_edge = sck_fall && s_nxt.bitc[cu][4:0] == 5'h00 && s_nxt.bitc[cu][5:0] != 6'h20
               ? 1'b1 : sck_fall && s_nxt.bitc[cu][4:0] == 5'h00;
         end else begin
            sck_rise = s_r.sck_s[cu][1] && !s_r.sck_d[cu];
            sck_fall = !s_r.sck_s[cu][1] && s_r.sck_d[cu];
            fs_edge = sck_fall && s_r.fs_dly[cu]; // R2
         end
         slot = s_r.bitc[cu][8:6] ^ {2'b00, s_r.bitc[cu][5] & ~s_r.clkcfg[cu][asc_pkg::ASC_CK_TDM_POS]};
         slot_on = !s_r.clkcfg[cu][asc_pkg::ASC_CK_TDM_POS] ||
            s_r.sercfg[m][asc_pkg::ASC_SC_SLOTEN_LSB + int'(slot)]; // R7
         nbits = asc_bits(s_r.sercfg[m][asc_pkg::ASC_SC_WS_LSB +: 3]); // R6
         if (s_r.sercfg[m][asc_pkg::ASC_SC_COMPACT_POS] && nbits > 6'h10) nbits = 6'h10;
         if (s_r.sercfg[m][asc_pkg::ASC_SC_MONO_POS] && s_r.bitc[cu][5] &&
             !s_r.clkcfg[cu][asc_pkg::ASC_CK_TDM_POS]) slot_on = 1'b0; // R6
         if (s_r.sercfg[m][asc_pkg::ASC_SC_PDM_POS] && !tx) begin
            // pdm: left on rising edge, right on falling edge, one bit per edge
            if ((sck_rise || (sck_fall && s_r.sercfg[m][asc_pkg::ASC_SC_PDM2_POS])) &&
                s_r.ctrl[2 + m]) begin // R8
               s_nxt.shreg[m] = {s_r.shreg[m][30:0], s_r.sd_s[m][1]};
               s_nxt.bitn[m] = s_r.bitn[m] + 6'h01;
               if (s_r.bitn[m] == 6'h1f) begin
                  s_nxt.bitn[m] = 6'h00;
                  s_nxt.data[m] = s_nxt.shreg[m];
                  if (s_r.full[m]) hw_set[asc_pkg::ASC_RXOR_POS + m] = 1'b1; // R15
                  s_nxt.full[m] = 1'b1;
                  hw_set[asc_pkg::ASC_RXRDY_POS + m] = 1'b1; // R16
                  s_nxt.rxtog[m] = ~s_r.rxtog[m];
               end
            end
         end else if (s_r.ctrl[2 + m]) begin
            if (fs_edge) s_nxt.bitn[m] = 6'h00;
            if (sck_fall && tx && slot_on) begin
               if (fs_edge || s_r.bitn[m] == 6'h00) begin
                  // compact stereo sends the low 16 bits of data in the left half first
                  s_nxt.shreg[m] = s_r.data[m] << (6'h20 - nbits);
                  if (s_r.sercfg[m][asc_pkg::ASC_SC_COMPACT_POS] && s_r.bitc[cu][5])
                     s_nxt.shreg[m] = s_r.data[m] << (6'h20 - (nbits >> 1)); // R4
                  if (!s_r.full[m]) hw_set[asc_pkg::ASC_TXUR_POS + m] = 1'b1; // R12
                  s_nxt.full[m] = 1'b0;
                  hw_set[asc_pkg::ASC_TXRDY_POS + m] = 1'b1; // R14
                  s_nxt.txtog[m] = ~s_r.txtog[m];
               end else begin
                  s_nxt.shreg[m] = {s_r.shreg[m][30:0], 1'b0};
               end
               s_nxt.sd_o[m] = s_nxt.shreg[m][31];
               s_nxt.bitn[m] = (fs_edge ? 6'h00 : s_r.bitn[m]) + 6'h01;
            end else if (sck_rise && !tx && slot_on && s_r.bitn[m] < nbits) begin
               s_nxt.shreg[m] = {s_r.shreg[m][30:0], s_r.sd_s[m][1]};
               s_nxt.bitn[m] = s_r.bitn[m] + 6'h01;
               if (s_r.bitn[m] == nbits - 6'h01) begin
                  if (s_r.sercfg[m][asc_pkg::ASC_SC_COMPACT_POS])
                     s_nxt.data[m] = {s_r.data[m][15:0], s_nxt.shreg[m][15:0]}; // R4
                  else
                     s_nxt.data[m] = s_nxt.shreg[m];
                  if (s_r.full[m]) hw_set[asc_pkg::ASC_RXOR_POS + m] = 1'b1; // R15
                  s_nxt.full[m] = 1'b1;
                  hw_set[asc_pkg::ASC_RXRDY_POS + m] = 1'b1; // R16
                  s_nxt.rxtog[m] = ~s_r.rxtog[m];
               end
            end
            if (s_nxt.bitn[m] >= nbits && sck_fall && !fs_edge) s_nxt.bitn[m] = 6'h00;
         end
         // dma: serializer m drives request line m; the split bit does not route anything
         s_nxt.drx[m] = s_nxt.flag[asc_pkg::ASC_RXRDY_POS + m] & ~tx; // R3
         s_nxt.dtx[m] = s_nxt.flag[asc_pkg::ASC_TXRDY_POS + m] & tx; // R3
      end
      // set wins over clear
      s_nxt.flag = ((s_r.flag & ~clr) | hw_set) & asc_pkg::ASC_IRQ_MASK; // R12 R13 R14 R15 R16
      for (int m = 0; m < asc_pkg::ASC_SER_N; m++) begin
         s_nxt.drx[m] = s_nxt.flag[asc_pkg::ASC_RXRDY_POS + m] &
            ~s_r.sercfg[m][asc_pkg::ASC_SC_TX_POS]; // R3
         s_nxt.dtx[m] = s_nxt.flag[asc_pkg::ASC_TXRDY_POS + m] &
            s_r.sercfg[m][asc_pkg::ASC_SC_TX_POS]; // R3
      end
      s_nxt.irq = |(s_nxt.flag & s_nxt.inten); // R17
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
         s_r.sercfg <= {asc_pkg::ASC_SERCFG_RST, asc_pkg::ASC_SERCFG_RST};
         s_r.flag <= asc_pkg::ASC_IRQFLAG_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   logic [1:0] split;
   assign split = {s_r.sercfg[1][asc_pkg::ASC_SC_SPLIT_POS], s_r.sercfg[0][asc_pkg::ASC_SC_SPLIT_POS]};
   assign prdata = s_r.prdata;
   assign pready = s_r.pready;
   assign pslverr = s_r.pslverr;
   assign irq = s_r.irq;
   assign master_clock_pin = s_r.mck;
   assign serial_clock_pin_o = s_r.sck;
   assign frame_sync_pin_o = s_r.fs;
   assign serial_data_pin_o = s_r.sd_o;
   assign dma_rx_req = s_r.drx;
   assign dma_tx_req = s_r.dtx;
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         serial_clock_pin_oe_n[c] = ~(s_r.ctrl[c] & s_r.clkcfg[c][asc_pkg::ASC_CK_MASTER_POS]); // R1
         frame_sync_pin_oe_n[c] = serial_clock_pin_oe_n[c];
         serial_data_pin_oe_n[c] = ~(s_r.ctrl[2 + c] & s_r.sercfg[c][asc_pkg::ASC_SC_TX_POS]);
      end
   end
   logic unused;
   assign unused = ^{setup, wr, rd, split, s_r.rxtog, s_r.txtog, s_r.mdiv};
endmodule : asc_controller
`default_nettype wire

// ==== asc_controller_sva.sv ====
// asc_controller_sva: port-level checks of the audio serial controller
// assumes: bound into asc_controller; the apb master keeps setup then access
`timescale 1ns/1ns
`default_nettype none
module asc_controller_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [1:0] serial_clock_pin_oe_n,
   input wire logic [1:0] frame_sync_pin_oe_n,
   input wire logic [1:0] master_clock_pin,
   input wire logic [1:0] dma_rx_req,
   input wire logic [1:0] dma_tx_req,
   input wire logic irq
);
   // ****************************************
   // decode
   // ****************************************
   logic mapped;
   logic done_wr;
   logic done_rd;
   assign mapped = (paddr[1:0] == 2'h0) && (paddr <= 8'h1c || paddr == 8'h30 || paddr == 8'h34);
   assign done_wr = psel && penable && pready && pwrite;
   assign done_rd = psel && penable && pready && !pwrite;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ****************************************
   // properties
   // ****************************************
   a_pready_one_wait: assert property ($rose(psel && penable) |=> pready)
      else $error("pready not one cycle after access");
   a_pready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_unmapped: assert property (pready |-> (pslverr == !mapped))
      else $error("pslverr does not match address map");
   a_fs_sck_oe: assert property (frame_sync_pin_oe_n == serial_clock_pin_oe_n)
      else $error("frame sync and serial clock enables differ");
   a_mck_runs: assert property ((!serial_clock_pin_oe_n[0])[*3] |->
      master_clock_pin[0] != $past(master_clock_pin[0])) else $error("master clock 0 not running");
   a_mck_idle: assert property (serial_clock_pin_oe_n[1][*3] |->
      $stable(master_clock_pin[1])) else $error("master clock 1 moves while slave");
   a_rd_clears_rx: assert property (done_rd && paddr == 8'h34 |=> !dma_rx_req[1])
      else $error("data read left rx request up");
   a_wr_clears_tx: assert property (done_wr && paddr == 8'h30 |=> !dma_tx_req[0])
      else $error("data write left tx request up");
   a_w0_keeps_tx: assert property (done_wr && paddr == 8'h14 && !pwdata[8] && dma_tx_req[0]
      |=> dma_tx_req[0]) else $error("writing zero cleared tx ready");
   a_irq_off: assert property (done_wr && paddr == 8'h10 && pwdata[15:0] == 16'hffff
      |-> ##[1:2] !irq) else $error("irq stays high with all enables cleared");
endmodule : asc_controller_sva
bind asc_controller asc_controller_sva i_asc_controller_sva (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pready, .pslverr, .serial_clock_pin_oe_n, .frame_sync_pin_oe_n,
   .master_clock_pin, .dma_rx_req, .dma_tx_req, .irq);
`default_nettype wire

// ==== asc_codec_model.sv ====
// asc_codec_model: i2s codec acting as clock master towards a slave clock unit
// assumes: run set by the bench; bit clock of 320 ns
`timescale 1ns/1ns
`default_nettype none
module asc_codec_model #(
   parameter logic [31:0] WORD = 32'ha5c30f96
) (
   input wire logic run,
   output logic sck,
   output logic fs,
   output logic sd
);
   // ****************************************
   // frame generator
   // ****************************************
   logic [5:0] pos;
   initial begin
      sck = 1'b0;
      fs = 1'b0;
      sd = 1'b0;
      pos = 6'h00;
      forever begin
         if (run) begin
            fs = pos[5];
            sd = WORD[~(pos[4:0] - 5'h01)];
            pos = pos + 6'h01;
         end else begin
            sd = ~sd; // idle line keeps moving, never a stale bit
         end
         #160;
         sck = run; // clock stands still outside frames
         #160;
         sck = 1'b0;
      end
   end
endmodule : asc_codec_model
`default_nettype wire

// ==== test_audio_serial_controller.sv ====
// test_audio_serial_controller: register-level bench of the audio serial controller
// assumes: asc_pkg, asc_controller, its checker and asc_codec_model compiled before
`timescale 1ns/1ns
`default_nettype none
module test_audio_serial_controller;
   // ****************************************
   // signals
   // ****************************************
   localparam logic [7:0] flg = asc_pkg::ASC_IRQFLAG_OFS;
   localparam logic [7:0] ien = asc_pkg::ASC_IRQENSET_OFS;
   localparam logic [7:0] icl = asc_pkg::ASC_IRQENCLR_OFS;
   localparam logic [7:0] ctl = asc_pkg::ASC_CTRL_OFS;
   localparam logic [31:0] word = 32'ha5c30f96;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, run, err;
   logic m_sck, m_fs, m_sd;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, v;
   logic [1:0] sck_o, sck_oe_n, fs_o, fs_oe_n, mck, sd_o, sd_oe_n, rx_req, tx_req;
   wire logic [1:0] sck_w, fs_w, sd_w;
   int fails, n_tests;
   // unit 0 lines have pull-downs; unit 1 lines belong to the codec
   assign sck_w = {sck_oe_n[1] ? m_sck : sck_o[1], sck_oe_n[0] ? 1'b0 : sck_o[0]};
   assign fs_w = {fs_oe_n[1] ? m_fs : fs_o[1], fs_oe_n[0] ? 1'b0 : fs_o[0]};
   assign sd_w = {sd_oe_n[1] ? m_sd : sd_o[1], sd_oe_n[0] ? 1'b0 : sd_o[0]};
   asc_controller i_asc_controller (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .serial_clock_pin_i(sck_w), .serial_clock_pin_o(sck_o),
      .serial_clock_pin_oe_n(sck_oe_n), .frame_sync_pin_i(fs_w), .frame_sync_pin_o(fs_o),
      .frame_sync_pin_oe_n(fs_oe_n), .master_clock_pin(mck), .serial_data_pin_i(sd_w),
      .serial_data_pin_o(sd_o), .serial_data_pin_oe_n(sd_oe_n), .dma_rx_req(rx_req),
      .dma_tx_req(tx_req), .irq);
   asc_codec_model #(.WORD(word)) i_asc_codec_model (.run, .sck(m_sck), .fs(m_fs), .sd(m_sd));
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   // ****************************************
   // tasks
   // ****************************************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      v = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      check("pready", {31'h0, pready}, 32'h1);
      if (pready !== 1'b1) tally_and_finish();
   endtask : apb
   task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] m,
         input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(what, v & m, exp);
   endtask : rdc
   // polls the flag register; long enough for a few audio frames
   task automatic waitf(input int b);
      int n;
      v = 32'h0;
      for (n = 0; n < 1000 && v[b] !== 1'b1; n++) begin
         apb(1'b0, flg, 32'h0);
      end
      check("flag set", {31'h0, v[b]}, 32'h1);
      if (v[b] !== 1'b1) tally_and_finish();
   endtask : waitf
   task automatic wirq(input logic exp);
      int n;
      for (n = 0; n < 8 && irq !== exp; n++) begin
         @(posedge pclk);
      end
      check("irq", {31'h0, irq}, {31'h0, exp});
      if (irq !== exp) tally_and_finish();
   endtask : wirq
   task automatic tally_and_finish;
      if (fails == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish
   // ****************************************
   // sequence
   // ****************************************
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      run = 1'b0;
      fails = 0;
      n_tests = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rdc("irq_flag_status_clear reset", flg, 32'hffff, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      check("unmapped error", {31'h0, err}, 32'h1);
      apb(1'b1, ien, 32'h1);
      apb(1'b1, ien, 32'h0);
      rdc("enable set", ien, 32'hffff, 32'h1);
      apb(1'b1, icl, 32'hffff);
      rdc("enable clear", ien, 32'hffff, 32'h0);
      apb(1'b1, asc_pkg::ASC_CLKCFG0_OFS, 32'h400f);
      apb(1'b1, asc_pkg::ASC_SERCFG0_OFS, 32'h3fe01);
      apb(1'b1, ctl, 32'h5);
      waitf(8);
      check("tx dma", {30'h0, tx_req}, 32'h1);
      check("sck drive", {30'h0, sck_oe_n}, 32'h2);
      apb(1'b1, ien, 32'h100);
      wirq(1'b1);
      apb(1'b1, asc_pkg::ASC_DATA0_OFS, word);
      rdc("tx ready clear", flg, 32'h100, 32'h0);
      waitf(12);
      waitf(8);
      apb(1'b1, flg, 32'h0);
      rdc("flags kept", flg, 32'h1100, 32'h1100);
      apb(1'b1, ctl, 32'h0);
      apb(1'b1, flg, 32'h1100);
      rdc("w1c tx", flg, 32'h1100, 32'h0);
      wirq(1'b0);
      apb(1'b1, asc_pkg::ASC_CLKCFG1_OFS, 32'h000f);
      apb(1'b1, asc_pkg::ASC_SERCFG1_OFS, 32'h3fe02);
      apb(1'b1, ctl, 32'ha);
      run <= 1'b1;
      // first word starts with the codec's first bit clock, before any select edge: thrown away
      waitf(1);
      apb(1'b0, asc_pkg::ASC_DATA1_OFS, 32'h0);
      waitf(1);
      rdc("rx word", asc_pkg::ASC_DATA1_OFS, 32'hffffffff, word);
      rdc("rx ready clear", flg, 32'h2, 32'h0);
      apb(1'b1, ien, 32'h20);
      waitf(5);
      wirq(1'b1);
      apb(1'b1, icl, 32'hffff);
      wirq(1'b0);
      run <= 1'b0;
      apb(1'b1, ctl, 32'h0);
      apb(1'b1, flg, 32'h22);
      rdc("w1c rx", flg, 32'h22, 32'h0);
      tally_and_finish();
   end
endmodule : test_audio_serial_controller
`default_nettype wire
